// *** bench/gsp_ctrl_model.sv ***
// Display controller model driving the common serial port
`timescale 1ns/10ps
`default_nettype none

module gsp_ctrl_model (
    output logic sck,     // Common shift clock, still between frames
    output logic sin,     // Serial data, MSB first
    output logic strobe,  // Latch strobe
    input wire logic sout // Serial readback
);
    initial begin
        sck = 1'b0;
        sin = 1'b0;
        strobe = 1'b0;
    end

    // Bare edges with idle data, so the link side sees reset come and go
    task automatic pulses(input int n);
        repeat (n) begin
            #3 sck = 1'b1;
            #3 sck = 1'b0;
        end
    endtask : pulses

    task automatic frame(input logic [287:0] w, input logic mode, output logic [287:0] cap);
        // Strobe left high by the last latch stays high for a correction write
        strobe = strobe & mode;
        for (int i = 287; i >= 0; i--) begin
            sin = w[i];
            #3 sck = 1'b1;
            #1 cap = {cap[286:0], sout};
            #2 sck = 1'b0;
        end
        // Pulled down when idle
        sin = 1'b0;
        #40 strobe = 1'b0;
        #16 strobe = 1'b1;
        // No edges until the strobe has been taken
        #40;
    endtask : frame
endmodule : gsp_ctrl_model
`default_nettype wire

// *** bench/test_gsp_serial_port_latch.sv ***
// Self-checking bench for the grayscale serial port and latch block
`timescale 1ns/10ps
`default_nettype none

module test_gsp_serial_port_latch;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic common_shift_clock, common_serial_in, latch_strobe, common_serial_out;
    logic red_group_pwm_clock = 1'b0;
    logic outputs_blank_n = 1'b0;
    logic correction_shift_clock = 1'b0;
    logic correction_serial_in = 1'b0;
    logic correction_serial_out, outputs_enable, overtemp_flag = 1'b0;
    logic [23:0] led_open_flag = 24'h0;
    logic [23:0] led_short_flag = 24'h0;
    logic [287:0] grayscale_value, last_gs, w, prev_w, cap, rb;
    logic [198:0] correction_latch, last_cl, c_word;
    logic [11:0] red_gs_count;
    logic [287:0] q_gs[$];
    logic [198:0] q_cl[$];
    logic modes [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    logic armed = 1'b0;
    int n_fail = 0;
    int total_checks = 0;
    int seed = 62777;
    int n;

    always #2 ref_clk = ~ref_clk;

    gsp_serial_port_latch gsp_serial_port_latch_inst (.ref_clk(ref_clk), .reset(reset),
        .common_shift_clock(common_shift_clock), .common_serial_in(common_serial_in),
        .latch_strobe(latch_strobe), .common_serial_out(common_serial_out),
        .red_group_pwm_clock(red_group_pwm_clock), .outputs_blank_n(outputs_blank_n),
        .correction_shift_clock(correction_shift_clock), .correction_serial_in(correction_serial_in),
        .correction_serial_out(correction_serial_out), .led_open_flag(led_open_flag),
        .led_short_flag(led_short_flag), .overtemp_flag(overtemp_flag), .grayscale_value(grayscale_value),
        .correction_latch(correction_latch), .red_gs_count(red_gs_count), .outputs_enable(outputs_enable));

    gsp_ctrl_model gsp_ctrl_model_inst (.sck(common_shift_clock), .sin(common_serial_in),
        .strobe(latch_strobe), .sout(common_serial_out));

    task automatic cmp_vec(input string name, input logic [287:0] e, input logic [287:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask : cmp_vec

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic drain();
        int k;
        for (k = 0; k < 50 && (q_gs.size() + q_cl.size()) != 0; k++) @(negedge ref_clk);
        if (k == 50) begin
            n_fail++;
            $display("Error latch update expected 0 pending seen %0d", q_gs.size() + q_cl.size());
            end_sim();
        end
    endtask : drain

    task automatic pwm_pulses(input int cnt);
        repeat (cnt) begin
            @(negedge ref_clk) red_group_pwm_clock = 1'b1;
            repeat (4) @(negedge ref_clk);
            red_group_pwm_clock = 1'b0;
            repeat (4) @(negedge ref_clk);
        end
        repeat (6) @(negedge ref_clk);
    endtask : pwm_pulses

    // A latch that moves with no note pending compares against zero and fails
    always @(negedge ref_clk) begin
        if (armed && grayscale_value !== last_gs) begin
            cmp_vec("grayscale latch", q_gs.size() ? q_gs.pop_front() : 288'h0, grayscale_value);
            last_gs = grayscale_value;
        end
        if (armed && correction_latch !== last_cl) begin
            cmp_vec("correction latch", {89'h0, q_cl.size() ? q_cl.pop_front() : 199'h0},
                {89'h0, correction_latch});
            last_cl = correction_latch;
        end
    end

    initial begin
        fork
            gsp_ctrl_model_inst.pulses(3);
            repeat (5) @(negedge ref_clk);
        join
        reset = 1'b0;
        gsp_ctrl_model_inst.pulses(4);
        repeat (5) @(negedge ref_clk);
        cmp_vec("enable", 288'h0, {287'h0, outputs_enable});
        outputs_blank_n = 1'b1;
        led_open_flag = 24'($random(seed));
        led_short_flag = 24'($random(seed));
        overtemp_flag = 1'($random(seed));
        last_gs = grayscale_value;
        last_cl = correction_latch;
        armed = 1'b1;
        n = 3 + ($unsigned($random(seed)) % 6);
        pwm_pulses(n);
        cmp_vec("red count", {276'h0, 12'(n)}, {276'h0, red_gs_count});
        cmp_vec("enable", 288'h1, {287'h0, outputs_enable});
        outputs_blank_n = 1'b0;
        pwm_pulses(2);
        cmp_vec("red count", 288'h0, {276'h0, red_gs_count});
        cmp_vec("enable", 288'h0, {287'h0, outputs_enable});
        outputs_blank_n = 1'b1;
        for (int f = 0; f < 4; f++) begin
            for (int b = 0; b < 9; b++) w[b*32 +: 32] = $random(seed);
            if (modes[f]) q_cl.push_back(w[198:0]);
            else q_gs.push_back(w);
            gsp_ctrl_model_inst.frame(w, modes[f], cap);
            drain();
            rb = {40'h0, overtemp_flag, led_short_flag, led_open_flag, c_word};
            if (f == 0) cmp_vec("serial out", {287'h0, w[287]}, cap);
            if (f == 3) cmp_vec("readback", {prev_w[286:285], rb[284:0], w[287]}, cap);
            if (modes[f]) begin
                c_word = w[198:0];
                cmp_vec("correction out", {287'h0, w[215]}, {287'h0, correction_serial_out});
                // Correction-port write only after the correction strobe, never before one
                correction_serial_in = ~w[213];
                repeat (5) @(negedge ref_clk);
                correction_shift_clock = 1'b1;
                repeat (5) @(negedge ref_clk);
                correction_shift_clock = 1'b0;
                repeat (6) @(negedge ref_clk);
                cmp_vec("correction out", {287'h0, w[214]}, {287'h0, correction_serial_out});
            end
            prev_w = w;
        end
        end_sim();
    end
endmodule : test_gsp_serial_port_latch
`default_nettype wire

// *** hw/gsp_pin_sync.sv ***
// Three-stage pin sampler with agreement filter
`timescale 1ns/10ps
`default_nettype none

module gsp_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,                // Sampling clock
    input wire logic reset,              // Synchronous, active high
    input wire logic [WIDTH-1:0] din,    // Asynchronous pin levels
    output logic [WIDTH-1:0] level       // Filtered levels, registered
);

    if (WIDTH < 1) begin : g_check
        $error("gsp_pin_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } gsp_sync_state_type;

    gsp_sync_state_type sync_r;
    gsp_sync_state_type sync_nxt;
    logic [WIDTH-1:0] agree;

    // ------------------------------------------------------------
    // A change counts only once stages two and three agree
    // ------------------------------------------------------------
    always_comb begin
        sync_nxt = sync_r;
        agree = ~(sync_r.s2 ^ sync_r.s3);
        sync_nxt.s1 = din;
        sync_nxt.s2 = sync_r.s1;
        sync_nxt.s3 = sync_r.s2;
        sync_nxt.level = (sync_r.level & ~agree) | (sync_r.s3 & agree);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign level = sync_r.level;

endmodule : gsp_pin_sync

`default_nettype wire

// *** hw/gsp_pkg.sv ***
// Shared constants of the grayscale serial port and latch block
package gsp_pkg;

    // ------------------------------------------------------------
    // Register sizes
    // ------------------------------------------------------------
    localparam int SR_BITS = 288;
    localparam int CORR_SR_BITS = 216;
    localparam int CORR_LATCH_BITS = 199;
    localparam int CORR_TAIL_LO = 199;
    localparam int CORR_TAIL_HI = 215;
    localparam int CHANNELS = 24;
    localparam int GS_CNT_BITS = 12;

    // ------------------------------------------------------------
    // Readback word layout, low bits first
    // ------------------------------------------------------------
    localparam int RB_OPEN_POS = 199;
    localparam int RB_SHORT_POS = 223;
    localparam int RB_TEMP_POS = 247;

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    localparam int SYNC_STAGES = 3;
    localparam int SYNC_IN_BITS = 6 + 2 * CHANNELS + 1;

endpackage : gsp_pkg

// *** hw/gsp_serial_port_latch.sv ***
// Common serial port, data latches, correction port and red grayscale counter
//
// Operation
// - Unblanked, each red PWM clock rising edge counts up
// - 288-bit register copied to one latch on strobe
// - Strobe low at last shift: grayscale latch
// - Strobe high: correction latch, tail to correction port
// - Shift edge: input into LSB, shift up
// - Serial output shows shift register MSB
// - Flags and correction latch readable on output
// - Blanking forces outputs off, counter zero
// - Correction register shifts on its own clock
`timescale 1ns/10ps
`default_nettype none

module gsp_serial_port_latch #(
    parameter int GS_CNT_BITS = gsp_pkg::GS_CNT_BITS
) (
    input wire logic ref_clk,                                        // Core clock
    input wire logic reset,                                          // Synchronous, active high
    input wire logic common_shift_clock,                             // Link clock of the common port
    input wire logic common_serial_in,                               // Serial data into LSB
    input wire logic latch_strobe,                                   // Latch strobe from controller
    output logic common_serial_out,                                  // Shift register MSB
    input wire logic red_group_pwm_clock,                            // Red group PWM reference
    input wire logic outputs_blank_n,                                // Low blanks all outputs
    input wire logic correction_shift_clock,                         // Correction port shift clock
    input wire logic correction_serial_in,                           // Correction port serial data
    output logic correction_serial_out,                              // Correction register MSB
    input wire logic [gsp_pkg::CHANNELS-1:0] led_open_flag,          // Open LED per channel
    input wire logic [gsp_pkg::CHANNELS-1:0] led_short_flag,         // Shorted LED per channel
    input wire logic overtemp_flag,                                  // Thermal error
    output logic [gsp_pkg::SR_BITS-1:0] grayscale_value,             // Grayscale latch
    output logic [gsp_pkg::CORR_LATCH_BITS-1:0] correction_latch,    // Correction/brightness/function latch
    output logic [GS_CNT_BITS-1:0] red_gs_count,                     // Red group grayscale counter
    output logic outputs_enable                                      // High while outputs may drive
);

    if (GS_CNT_BITS < 1 || GS_CNT_BITS > 16) begin : g_check
        $error("gsp_serial_port_latch: GS_CNT_BITS out of range");
    end

    localparam int SR = gsp_pkg::SR_BITS;
    localparam int CSR = gsp_pkg::CORR_SR_BITS;
    localparam int CL = gsp_pkg::CORR_LATCH_BITS;
    localparam int NCH = gsp_pkg::CHANNELS;

    // ------------------------------------------------------------
    // State of each clock domain
    // ------------------------------------------------------------
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic reload_s1;
        logic reload_s2;
        logic reload_seen;
        logic mode;
        logic [SR-1:0] sr;
        logic sout;
    } gsp_link_state_type;

    typedef struct packed {
        logic strobe_prev;
        logic pwm_prev;
        logic cclk_prev;
        logic reload_tgl;
        logic [SR-1:0] readback;
        logic [SR-1:0] gs_latch;
        logic [CL-1:0] corr_latch;
        logic [CSR-1:0] corr_sr;
        logic corr_sout;
        logic [GS_CNT_BITS-1:0] gs_count;
        logic out_en;
    } gsp_ref_state_type;

    gsp_link_state_type link_r;
    gsp_link_state_type link_nxt;
    gsp_ref_state_type ref_r;
    gsp_ref_state_type ref_nxt;

    logic [gsp_pkg::SYNC_IN_BITS-1:0] pins_lvl;
    logic strobe_lvl;
    logic mode_lvl;
    logic pwm_lvl;
    logic blank_n_lvl;
    logic cclk_lvl;
    logic csin_lvl;
    logic [NCH-1:0] open_lvl;
    logic [NCH-1:0] short_lvl;
    logic temp_lvl;
    logic strobe_rise;
    logic pwm_rise;
    logic cclk_rise;

    gsp_pin_sync #(
        .WIDTH(gsp_pkg::SYNC_IN_BITS)
    ) u_pins (
        .clk(ref_clk),
        .reset(reset),
        .din({latch_strobe, link_r.mode, red_group_pwm_clock, outputs_blank_n,
              correction_shift_clock, correction_serial_in, led_open_flag,
              led_short_flag, overtemp_flag}),
        .level(pins_lvl)
    );

    assign {strobe_lvl, mode_lvl, pwm_lvl, blank_n_lvl, cclk_lvl, csin_lvl,
            open_lvl, short_lvl, temp_lvl} = pins_lvl;
    assign strobe_rise = strobe_lvl & ~ref_r.strobe_prev;
    assign pwm_rise = pwm_lvl & ~ref_r.pwm_prev;
    assign cclk_rise = cclk_lvl & ~ref_r.cclk_prev;

    // ------------------------------------------------------------
    // Link domain: common shift register
    // ------------------------------------------------------------
    // Reset and reload request reach this domain through two flops each.
    // The readback word is held steady until the next strobe, so it is
    // read here only after the reload toggle has crossed.
    // Bits shifted in while the toggle crosses are kept, so a frame stays
    // whole; the top three readback bits, always zero, are skipped.
    always_comb begin
        link_nxt = link_r;
        link_nxt.rst_s1 = reset;
        link_nxt.rst_s2 = link_r.rst_s1;
        link_nxt.reload_s1 = ref_r.reload_tgl;
        link_nxt.reload_s2 = link_r.reload_s1;
        if (link_r.rst_s2) begin
            link_nxt.reload_seen = link_r.reload_s2;
            link_nxt.mode = 1'b0;
            link_nxt.sr = '0;
        end else begin
            link_nxt.mode = latch_strobe;
            if (link_r.reload_s2 != link_r.reload_seen) begin
                link_nxt.reload_seen = link_r.reload_s2;
                link_nxt.sr = {ref_r.readback[SR-4:0], link_r.sr[1:0], common_serial_in};
            end else begin
                link_nxt.sr = {link_r.sr[SR-2:0], common_serial_in};
            end
        end
        link_nxt.sout = link_nxt.sr[SR-1];
    end

    always_ff @(posedge common_shift_clock) begin
        link_r <= link_nxt;
    end

    // ------------------------------------------------------------
    // Core domain: latches, correction port, PWM counter
    // ------------------------------------------------------------
    // The shift register word is taken while the link clock is idle;
    // the strobe only rises after the final shift edge.
    always_comb begin
        ref_nxt = ref_r;
        ref_nxt.strobe_prev = strobe_lvl;
        ref_nxt.pwm_prev = pwm_lvl;
        ref_nxt.cclk_prev = cclk_lvl;
        if (cclk_rise) begin
            ref_nxt.corr_sr = {ref_r.corr_sr[CSR-2:0], csin_lvl};
        end
        if (strobe_rise) begin
            if (!mode_lvl) begin
                ref_nxt.gs_latch = link_r.sr;
            end else begin
                ref_nxt.corr_latch = link_r.sr[CL-1:0];
                ref_nxt.corr_sr[gsp_pkg::CORR_TAIL_HI:gsp_pkg::CORR_TAIL_LO] =
                    link_r.sr[gsp_pkg::CORR_TAIL_HI:gsp_pkg::CORR_TAIL_LO];
            end
            ref_nxt.readback = '0;
            ref_nxt.readback[CL-1:0] = ref_nxt.corr_latch;
            ref_nxt.readback[gsp_pkg::RB_OPEN_POS +: NCH] = open_lvl;
            ref_nxt.readback[gsp_pkg::RB_SHORT_POS +: NCH] = short_lvl;
            ref_nxt.readback[gsp_pkg::RB_TEMP_POS] = temp_lvl;
            ref_nxt.reload_tgl = ~ref_r.reload_tgl;
        end
        ref_nxt.corr_sout = ref_nxt.corr_sr[CSR-1];
        if (!blank_n_lvl) begin
            ref_nxt.gs_count = '0;
            ref_nxt.out_en = 1'b0;
        end else begin
            ref_nxt.out_en = 1'b1;
            if (pwm_rise) begin
                ref_nxt.gs_count = ref_r.gs_count + GS_CNT_BITS'(1);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ref_r <= '0;
        end else begin
            ref_r <= ref_nxt;
        end
    end

    assign common_serial_out = link_r.sout;
    assign correction_serial_out = ref_r.corr_sout;
    assign grayscale_value = ref_r.gs_latch;
    assign correction_latch = ref_r.corr_latch;
    assign red_gs_count = ref_r.gs_count;
    assign outputs_enable = ref_r.out_en;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pwm_count_step: assert property (@(posedge ref_clk) disable iff (reset)
        (blank_n_lvl && pwm_rise) |=> red_gs_count == $past(red_gs_count) + GS_CNT_BITS'(1))
        else $error("red counter did not step on PWM edge");

    a_count_holds: assert property (@(posedge ref_clk) disable iff (reset)
        (blank_n_lvl && !pwm_rise) |=> $stable(red_gs_count))
        else $error("red counter moved without PWM edge");

    a_blank_clears: assert property (@(posedge ref_clk) disable iff (reset)
        !blank_n_lvl |=> (red_gs_count == '0) && !outputs_enable)
        else $error("blanking did not clear counter and outputs");

    a_gs_latch_load: assert property (@(posedge ref_clk) disable iff (reset)
        (strobe_rise && !mode_lvl) |=> grayscale_value == $past(link_r.sr))
        else $error("grayscale latch not loaded");

    a_corr_latch_load: assert property (@(posedge ref_clk) disable iff (reset)
        (strobe_rise && mode_lvl) |=> (correction_latch == $past(link_r.sr[CL-1:0]))
        && (ref_r.corr_sr[gsp_pkg::CORR_TAIL_HI:gsp_pkg::CORR_TAIL_LO]
        == $past(link_r.sr[gsp_pkg::CORR_TAIL_HI:gsp_pkg::CORR_TAIL_LO]))
        && $stable(grayscale_value))
        else $error("correction latch or tail not loaded");

    a_readback_fill: assert property (@(posedge ref_clk) disable iff (reset)
        strobe_rise |=> (ref_r.readback[CL-1:0] == correction_latch)
        && (ref_r.readback[gsp_pkg::RB_TEMP_POS] == $past(temp_lvl))
        && (ref_r.reload_tgl != $past(ref_r.reload_tgl)))
        else $error("readback word not refreshed");

    a_corr_shift: assert property (@(posedge ref_clk) disable iff (reset)
        (cclk_rise && !strobe_rise) |=> (ref_r.corr_sr == {$past(ref_r.corr_sr[CSR-2:0]), $past(csin_lvl)})
        ##1 1'b1)
        else $error("correction register did not shift");

    a_link_shift: assert property (@(posedge common_shift_clock) disable iff (link_r.rst_s2)
        (link_r.reload_s2 == link_r.reload_seen) |=> (link_r.sr[SR-1:1] == $past(link_r.sr[SR-2:0]))
        && (link_r.sr[0] == $past(common_serial_in)))
        else $error("common register did not shift");

    a_sout_msb: assert property (@(posedge common_shift_clock) disable iff (reset || link_r.rst_s2)
        1'b1 |-> common_serial_out == link_r.sr[SR-1])
        else $error("serial output is not the MSB");

    a_reload_keeps: assert property (@(posedge common_shift_clock) disable iff (link_r.rst_s2)
        (link_r.reload_s2 != link_r.reload_seen) |=> (link_r.sr[SR-1:3] == $past(ref_r.readback[SR-4:0]))
        && (link_r.sr[2:0] == {$past(link_r.sr[1:0]), $past(common_serial_in)}))
        else $error("readback load lost shifted data");

endmodule : gsp_serial_port_latch

`default_nettype wire
